/* File: rtl/uim_ctrl.v */
`timescale 1ns/1ps
`include "uim_regs.vh"
module uim_ctrl (
    input  wire        ref_clk_i,         // System clock, 200 MHz
    input  wire        rst_i,             // Async reset, active high
    input  wire        reg_wr_i,          // Register write strobe (32-bit word)
    input  wire        reg_rd_i,          // Register read strobe
    input  wire [7:0]  reg_addr_i,        // Register byte address
    input  wire [31:0] reg_wdata_i,       // Write data
    output reg  [31:0] reg_rdata_o,       // Read data, valid cycle after read
    input  wire [7:0]  utmi_data_i,       // Receive data byte
    input  wire        utmi_rxvalid_i,    // Receive byte valid
    input  wire        utmi_rxactive_i,   // Receive active
    input  wire        utmi_rxerror_i,    // Receive error
    input  wire [1:0]  utmi_linestate_i,  // Line state
    input  wire [5:0]  otg_stat_i,        // Bvalid,idgnd,hostdis,vbusvld,sessvld,sessend
    input  wire [2:0]  serial_rx_i,       // Rx differential, D-minus, D-plus
    output wire [1:0]  utmi_opmode_o,     // Operating mode
    output wire        utmi_opmode2_o,    // Operating mode top bit
    output wire        utmi_termsel_o,    // Termination select
    output wire        utmi_xcvrsel_o,    // Transceiver select
    output wire [7:0]  otg_ctrl_o,        // OTG control bits 7:0 (bit 5 zero)
    output wire        tx_se0_o,          // Serial transmit SE0
    output wire        tx_data_o,         // Serial transmit data
    output wire        tx_enable_n_o,     // Serial transmit enable, active low
    output wire        fsls_serial_o,     // Serial mode select
    output wire [7:0]  feature_o,         // Feature enables to the machine
    output reg         token_valid_o,     // Pulse: accepted token for us
    output wire        flag_output_port_a_o, // Flag port a
    output wire        flag_output_port_b_o, // Flag port b
    output wire        flag_output_port_c_o  // Flag port c
);
    // Pin-side inputs pass two flops
    reg [15:0] s1;
    reg [15:0] s2;
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1 <= 16'h0000;
            s2 <= 16'h0000;
        end else begin
            s1 <= {otg_stat_i, serial_rx_i, utmi_linestate_i, utmi_rxerror_i,
                   utmi_rxactive_i, utmi_rxvalid_i, 2'h0};
            s2 <= s1;
        end
    end
    // Slices of the second stage; only these are read by the logic
    wire [5:0] otg_sync  = s2[15:10];
    wire [2:0] ser_sync  = s2[9:7];
    wire [1:0] ls_sync   = s2[6:5];
    wire       rxerr_s   = s2[4];
    wire       rxact_s   = s2[3];
    wire       rxvalid_s = s2[2];
    // Data byte follows rxvalid through the same two stages
    reg [7:0] d1;
    reg [7:0] d2;
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            d1 <= 8'h00;
            d2 <= 8'h00;
        end else begin
            d1 <= utmi_data_i;
            d2 <= d1;
        end
    end

    // Write decode; any data written to the reset offset counts
    wire wr      = reg_wr_i;
    wire soft_rst = wr && (reg_addr_i == `UIM_OFF_RESET);
    // Address match for a write in this cycle
    function sel;
        input [7:0] a;
        input [7:0] off;
        begin
            sel = wr && (a == off);
        end
    endfunction

    // Control registers
    reg [7:0]  feature;
    reg [6:0]  dev_addr;
    reg [4:0]  func;
    reg [7:0]  otg_ctrl;
    reg [3:0]  serial;
    reg [6:0]  hold;
    reg [23:0] port_mask;
    reg [15:0] ep_match;
    reg [31:0] otg_mask;
    reg [8:0]  power;
    reg [18:0] aux;
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            feature   <= `UIM_RST_FEATURE;
            dev_addr  <= 7'h00;
            func      <= `UIM_RST_FUNC;
            otg_ctrl  <= 8'h00;
            serial    <= `UIM_RST_SERIAL;
            hold      <= 7'h00;
            port_mask <= 24'h000000;
            ep_match  <= 16'h0000;
            otg_mask  <= 32'h00000000;
            power     <= 9'h000;
            aux       <= 19'h00000;
        end else if (soft_rst) begin
            // Machine state only; transceiver-facing controls kept
            feature   <= `UIM_RST_FEATURE;
            dev_addr  <= 7'h00;
            hold      <= 7'h00;
            port_mask <= 24'h000000;
            ep_match  <= 16'h0000;
        end else begin
            if (sel(reg_addr_i, `UIM_OFF_FEATURE))
                feature <= reg_wdata_i[7:0] & 8'hf7;
            if (sel(reg_addr_i, `UIM_OFF_DEVADDR))
                dev_addr <= reg_wdata_i[6:0];
            if (sel(reg_addr_i, `UIM_OFF_FUNC))
                func <= reg_wdata_i[4:0];
            if (sel(reg_addr_i, `UIM_OFF_OTG_CTRL))
                otg_ctrl <= reg_wdata_i[7:0] & 8'hdf;
            if (sel(reg_addr_i, `UIM_OFF_SERIAL))
                serial <= reg_wdata_i[3:0];
            if (sel(reg_addr_i, `UIM_OFF_HOLD))
                hold <= reg_wdata_i[6:0];
            if (sel(reg_addr_i, `UIM_OFF_PORTMASK))
                port_mask <= reg_wdata_i[23:0];
            if (sel(reg_addr_i, `UIM_OFF_EP_MATCH))
                ep_match <= reg_wdata_i[15:0];
            if (sel(reg_addr_i, `UIM_OFF_OTG_MASK))
                otg_mask <= reg_wdata_i;
            if (sel(reg_addr_i, `UIM_OFF_POWER))
                power <= reg_wdata_i[8:0];
            if (sel(reg_addr_i, `UIM_OFF_AUX))
                aux <= reg_wdata_i[18:0] & 19'h43ff0;
        end
    end

    // Transceiver-facing outputs come straight from their registers
    assign feature_o      = feature;
    assign utmi_opmode_o  = func[3:2];
    assign utmi_opmode2_o = func[4];
    assign utmi_termsel_o = func[1];
    assign utmi_xcvrsel_o = func[0];
    assign otg_ctrl_o     = otg_ctrl;
    assign tx_se0_o       = serial[3];
    assign tx_data_o      = serial[2];
    assign tx_enable_n_o  = serial[1];
    assign fsls_serial_o  = serial[0];

    // Receive parser: byte 0 PID, bytes 1..2 token body or data
    reg         rxact_q;
    reg  [1:0]  bcnt;
    reg  [3:0]  cur_pid;
    reg  [7:0]  tok_lo;
    reg  [4:0]  crc5;
    reg  [15:0] crc16;
    wire [4:0]  n5;
    wire [15:0] n16;
    // CRC covers the body bytes only; the PID byte has its own check
    uim_crc u_crc (
        .data_i  (d2),
        .crc5_i  (crc5),
        .crc16_i (crc16),
        .crc5_o  (n5),
        .crc16_o (n16)
    );
    // Packet framing from edges of the synchronised receive-active
    wire pkt_start = rxact_s && !rxact_q;
    wire pkt_end   = !rxact_s && rxact_q;
    wire pid_ok    = (d2[7:4] == ~d2[3:0]);
    // Token PIDs; start-of-frame counts only when enabled
    wire is_token  = (cur_pid == `UIM_PID_OUT) || (cur_pid == `UIM_PID_IN) ||
                     (cur_pid == `UIM_PID_SETUP) ||
                     (feature[`UIM_FEAT_SOF_TOKEN] && cur_pid == `UIM_PID_SOF);
    wire is_data   = (cur_pid[1:0] == 2'b11);
    wire tok_crc_ok = !feature[`UIM_FEAT_TOKEN_CHECK] || (crc5 == `UIM_CRC5_RES);
    wire addr_ok    = (tok_lo[6:0] == dev_addr) || (cur_pid == `UIM_PID_SOF);
    // Short bodies are refused by the byte count; it saturates at 3, so long ones pass it
    wire tok_done   = pkt_end && is_token && (bcnt == 2'd3) &&
                      feature[`UIM_FEAT_TOKEN_PROC] && tok_crc_ok && addr_ok;
    wire crc16_bad  = pkt_end && is_data && (crc16 != `UIM_CRC16_RES);
    // Captured packet results
    reg  [10:0] frame;
    reg  [3:0]  last_pid;
    reg  [4:0]  last_ep;
    reg         pid_good;
    reg  [7:0]  d2_hi_q;
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rxact_q <= 1'b0;
            bcnt <= 2'd0;
            cur_pid <= 4'h0;
            tok_lo <= 8'h00;
            crc5 <= 5'h1f;
            crc16 <= 16'hffff;
            frame <= 11'h000;
            last_pid <= 4'h0;
            last_ep <= 5'h00;
            pid_good <= 1'b0;
            token_valid_o <= 1'b0;
        end else if (soft_rst) begin
            // A packet in flight is lost; its remainder parses as a new one
            rxact_q <= 1'b0;
            bcnt <= 2'd0;
            cur_pid <= 4'h0;
            tok_lo <= 8'h00;
            crc5 <= 5'h1f;
            crc16 <= 16'hffff;
            frame <= 11'h000;
            last_pid <= 4'h0;
            last_ep <= 5'h00;
            pid_good <= 1'b0;
            token_valid_o <= 1'b0;
        end else begin
            rxact_q <= rxact_s;
            token_valid_o <= tok_done && pid_good;
            if (pkt_start) begin
                bcnt <= 2'd0;
                crc5 <= 5'h1f;
                crc16 <= 16'hffff;
            end else if (rxvalid_s && rxact_s) begin
                if (bcnt != 2'd3)
                    bcnt <= bcnt + 2'd1;
                if (bcnt == 2'd0) begin
                    cur_pid  <= d2[3:0];
                    pid_good <= pid_ok;
                    last_pid <= d2[3:0];
                end else begin
                    if (bcnt == 2'd1)
                        tok_lo <= d2;
                    crc5  <= n5;
                    crc16 <= n16;
                end
            end
            // SOF loads the frame field; other tokens update the endpoint
            if (tok_done && pid_good) begin
                if (cur_pid == `UIM_PID_SOF)
                    frame <= {d2_hi_q[2:0], tok_lo};
                else
                    last_ep <= {1'b1, d2_hi_q[2:0], tok_lo[7]};
            end
            // Software write is last so it wins over a same-cycle frame load
            if (sel(reg_addr_i, `UIM_OFF_FRAME))
                frame <= reg_wdata_i[10:0];
        end
    end
    // Second token byte kept for endpoint high bits and frame top
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            d2_hi_q <= 8'h00;
        else if (rxvalid_s && rxact_s && bcnt == 2'd2)
            d2_hi_q <= d2;
    end

    // Event flags: sources set, held bits wait for a write of one
    reg  [6:0] flags;
    reg  [6:0] next_flags;
    reg  [6:0] ev;
    // Line-state flags only while the decoder is enabled; clear bits from a write
    wire       ls_en = feature[`UIM_FEAT_LINE_DECODE];
    wire [6:0] clr = sel(reg_addr_i, `UIM_OFF_FLAGS) ? reg_wdata_i[6:0] : 7'h00;
    always @* begin
        ev = 7'h00;
        ev[`UIM_FLG_TOKEN] = tok_done && pid_good;
        ev[`UIM_FLG_SE0]   = ls_en && (ls_sync == `UIM_LS_SE0);
        ev[`UIM_FLG_K]     = ls_en && (ls_sync == `UIM_LS_K);
        ev[`UIM_FLG_J]     = ls_en && (ls_sync == `UIM_LS_J);
        ev[`UIM_FLG_CRC16] = crc16_bad;
        ev[`UIM_FLG_RXACT] = rxact_s;
        ev[`UIM_FLG_RXERR] = rxerr_s;
        // Normal flags: token and CRC16 cleared at packet start, else held; the others overwritten by source
        next_flags = pkt_start ? 7'h00 : flags;
        next_flags[5:3] = ev[5:3];
        next_flags[`UIM_FLG_RXACT] = rxact_s;
        next_flags[`UIM_FLG_RXERR] = rxerr_s;
        next_flags = next_flags | ev;
        // Held flags: set wins over a software clear in the same cycle
        next_flags = (next_flags & ~hold) | (((flags & ~clr) | ev) & hold);
    end
    // Flag register; the machine reset clears held flags too
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            flags <= 7'h00;
        else if (soft_rst)
            flags <= 7'h00;
        else
            flags <= next_flags;
    end

    // Flag ports: OR of masked flags
    assign flag_output_port_a_o = |(flags & port_mask[6:0]);
    assign flag_output_port_b_o = |(flags & port_mask[14:8]);
    assign flag_output_port_c_o = |(flags & port_mask[22:16]);

    // Read mux; unmapped and write-only addresses read zero
    // Status fields lag their pins by the two sync stages
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `UIM_OFF_FEATURE:  reg_rdata_o <= {24'h0, feature};
                `UIM_OFF_DEVADDR:  reg_rdata_o <= {25'h0, dev_addr};
                `UIM_OFF_FUNC:     reg_rdata_o <= {27'h0, func};
                `UIM_OFF_OTG_CTRL: reg_rdata_o <= {24'h0, otg_ctrl};
                `UIM_OFF_OTG_STAT: reg_rdata_o <= {26'h0, otg_sync};
                `UIM_OFF_SERIAL:   reg_rdata_o <= {25'h0, ser_sync, serial};
                `UIM_OFF_FLAGS:    reg_rdata_o <= {25'h0, flags};
                `UIM_OFF_HOLD:     reg_rdata_o <= {25'h0, hold};
                `UIM_OFF_PORTMASK: reg_rdata_o <= {8'h0, port_mask};
                `UIM_OFF_FRAME:    reg_rdata_o <= {21'h0, frame};
                `UIM_OFF_PID:      reg_rdata_o <= {28'h0, last_pid};
                `UIM_OFF_ENDPOINT: reg_rdata_o <= {27'h0, last_ep};
                `UIM_OFF_EP_MATCH: reg_rdata_o <= {16'h0, ep_match};
                `UIM_OFF_OTG_MASK: reg_rdata_o <= otg_mask;
                `UIM_OFF_POWER:    reg_rdata_o <= {23'h0, power};
                `UIM_OFF_AUX:      reg_rdata_o <= {13'h0, aux};
                default:           reg_rdata_o <= 32'h00000000;
            endcase
        end
    end
endmodule

/* File: include/uim_regs.vh */
`ifndef UIM_REGS_VH
`define UIM_REGS_VH
// Register word offsets (byte addresses)
`define UIM_OFF_RESET      8'h00
`define UIM_OFF_FEATURE    8'h04
`define UIM_OFF_DEVADDR    8'h08
`define UIM_OFF_FUNC       8'h0c
`define UIM_OFF_OTG_CTRL   8'h10
`define UIM_OFF_OTG_STAT   8'h14
`define UIM_OFF_SERIAL     8'h18
`define UIM_OFF_FLAGS      8'h1c
`define UIM_OFF_HOLD       8'h20
`define UIM_OFF_PORTMASK   8'h24
`define UIM_OFF_FRAME      8'h28
`define UIM_OFF_PID        8'h2c
`define UIM_OFF_ENDPOINT   8'h30
`define UIM_OFF_EP_MATCH   8'h34
`define UIM_OFF_OTG_MASK   8'h38
`define UIM_OFF_POWER      8'h3c
`define UIM_OFF_AUX        8'h40
// Feature control bit positions
`define UIM_FEAT_TOKEN_PROC   0
`define UIM_FEAT_TOKEN_CHECK  1
`define UIM_FEAT_LINE_DECODE  2
`define UIM_FEAT_IF_TIMING    4
`define UIM_FEAT_POWER_SIG    5
`define UIM_FEAT_SOF_TOKEN    6
`define UIM_FEAT_EXT_ACK      7
// Flag bit positions
`define UIM_FLG_TOKEN   6
`define UIM_FLG_SE0     5
`define UIM_FLG_K       4
`define UIM_FLG_J       3
`define UIM_FLG_CRC16   2
`define UIM_FLG_RXACT   1
`define UIM_FLG_RXERR   0
// Reset values
`define UIM_RST_FEATURE  8'h00
`define UIM_RST_FUNC     5'h07
`define UIM_RST_SERIAL   4'h2
// PID codes (4-bit, low nibble)
`define UIM_PID_OUT    4'h1
`define UIM_PID_IN     4'h9
`define UIM_PID_SOF    4'h5
`define UIM_PID_SETUP  4'hd
// Line states
`define UIM_LS_SE0  2'h0
`define UIM_LS_J    2'h1
`define UIM_LS_K    2'h2
`define UIM_CRC5_RES   5'h0c
`define UIM_CRC16_RES  16'h800d
`endif

/* File: rtl/uim_crc.v */
`timescale 1ns/1ps
`include "uim_regs.vh"
// Byte-wide CRC5 and CRC16 update, LSB first as on the wire
module uim_crc (
    input  wire [7:0]  data_i,   // Received byte
    input  wire [4:0]  crc5_i,   // Current CRC5
    input  wire [15:0] crc16_i,  // Current CRC16
    output reg  [4:0]  crc5_o,   // Updated CRC5
    output reg  [15:0] crc16_o   // Updated CRC16
);
    integer i;
    reg     fb5;
    reg     fb16;
    // Bit-serial loop unrolled by the tool; one byte per cycle
    always @* begin
        crc5_o  = crc5_i;
        crc16_o = crc16_i;
        fb5     = 1'b0;
        fb16    = 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            fb5     = crc5_o[4] ^ data_i[i];
            crc5_o  = {crc5_o[3:0], 1'b0} ^ (fb5 ? 5'h05 : 5'h00);
            fb16    = crc16_o[15] ^ data_i[i];
            crc16_o = {crc16_o[14:0], 1'b0} ^ (fb16 ? 16'h8005 : 16'h0000);
        end
    end
endmodule

/* File: bench/uim_phy_model.sv */
`timescale 1ns/1ps
// Behavioural transceiver: receive bytes, line state and status lines
module uim_phy_model (
    input  wire        ref_clk_i,   // System clock
    output logic [7:0] data_o,      // Receive byte
    output logic       rxvalid_o,   // Byte valid
    output logic       rxactive_o,  // Packet in progress
    output logic       rxerror_o,   // Receive error
    output logic [1:0] ls_o,        // Line state
    output logic [5:0] otg_o,       // Session and bus status
    output logic [2:0] srx_o        // Serial receive lines
);
    // Idle state at time zero, line at J
    initial begin
        data_o = 8'h00; rxvalid_o = 1'b0; rxactive_o = 1'b0; rxerror_o = 1'b0;
        ls_o = 2'h1; otg_o = 6'h00; srx_o = 3'h0;
    end
    // One packet: PID then two body bytes, a gap cycle after each byte
    task send(input [7:0] pid, input [7:0] b1, input [7:0] b2);
        logic [7:0] b [0:2];
        b[0] = pid; b[1] = b1; b[2] = b2;
        @(posedge ref_clk_i) rxactive_o <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk_i) begin data_o <= b[i]; rxvalid_o <= 1'b1; end
            // Released data is inverted so a stale byte never looks valid
            @(posedge ref_clk_i) begin data_o <= ~b[i]; rxvalid_o <= 1'b0; end
        end
        @(posedge ref_clk_i) rxactive_o <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
    endtask
    task set_lines(input [1:0] ls, input err, input [5:0] otg, input [2:0] srx);
        @(posedge ref_clk_i) begin ls_o <= ls; rxerror_o <= err; otg_o <= otg; srx_o <= srx; end
    endtask
endmodule

/* File: bench/uim_ctrl_props.sv */
`timescale 1ns/1ps
module uim_ctrl_props (
    input wire        ref_clk_i,      // Clock
    input wire        rst_i,          // Reset
    input wire        reg_wr_i,       // Write strobe
    input wire        reg_rd_i,       // Read strobe
    input wire [7:0]  reg_addr_i,     // Address
    input wire [31:0] reg_wdata_i,    // Write data
    input wire [31:0] reg_rdata_o,    // Read data
    input wire [5:0]  otg_stat_i,     // Status lines
    input wire [1:0]  utmi_opmode_o,  // Mode
    input wire        utmi_opmode2_o, // Mode top bit
    input wire        utmi_termsel_o, // Termination
    input wire        utmi_xcvrsel_o, // Transceiver select
    input wire [7:0]  otg_ctrl_o,     // OTG control
    input wire        tx_se0_o,       // Tx SE0
    input wire        tx_data_o,      // Tx data
    input wire        tx_enable_n_o,  // Tx enable
    input wire        fsls_serial_o,  // Serial mode
    input wire [7:0]  feature_o,      // Features
    input wire        token_valid_o,  // Token pulse
    input wire        flag_output_port_a_o // Flag port
);
    logic [1:0] cyc;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Settles after three clean cycles so the status sync stages hold real values
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) cyc <= 2'd0;
        else if (cyc != 2'd3) cyc <= cyc + 2'd1;
    end
    a_func_write: assert property (reg_wr_i && reg_addr_i == 8'h0c |=>
        {utmi_opmode2_o, utmi_opmode_o, utmi_termsel_o, utmi_xcvrsel_o} == $past(reg_wdata_i[4:0]))
        else $error("function outputs differ from written value");
    a_otg_write: assert property (reg_wr_i && reg_addr_i == 8'h10 |=>
        otg_ctrl_o == ($past(reg_wdata_i[7:0]) & 8'hdf)) else $error("otg control mismatch");
    a_serial_write: assert property (reg_wr_i && reg_addr_i == 8'h18 |=>
        {tx_se0_o, tx_data_o, tx_enable_n_o, fsls_serial_o} == $past(reg_wdata_i[3:0]))
        else $error("serial outputs mismatch");
    a_feature_write: assert property (reg_wr_i && reg_addr_i == 8'h04 |=>
        feature_o == ($past(reg_wdata_i[7:0]) & 8'hf7)) else $error("feature mismatch");
    a_reset_clears: assert property (reg_wr_i && reg_addr_i == 8'h00 |=>
        feature_o == 8'h00 && !flag_output_port_a_o) else $error("state not cleared");
    a_reset_keeps: assert property (reg_wr_i && reg_addr_i == 8'h00 |=>
        $stable({utmi_opmode2_o, utmi_opmode_o, utmi_termsel_o, utmi_xcvrsel_o, otg_ctrl_o}))
        else $error("transceiver controls disturbed");
    a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without read");
    a_status_read: assert property (cyc == 2'd3 && reg_rd_i && reg_addr_i == 8'h14 &&
        $stable(otg_stat_i) && $past(otg_stat_i, 2) == otg_stat_i &&
        $past(otg_stat_i, 3) == otg_stat_i |=> reg_rdata_o == {26'h0, $past(otg_stat_i)})
        else $error("status read mismatch");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 8'h40 |=>
        reg_rdata_o == 32'h0) else $error("unmapped read not zero");
    a_token_pulse: assert property (token_valid_o |=> !token_valid_o)
        else $error("token pulse too long");
endmodule
bind uim_ctrl uim_ctrl_props u_props (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .otg_stat_i(otg_stat_i), .utmi_opmode_o(utmi_opmode_o), .utmi_opmode2_o(utmi_opmode2_o),
    .utmi_termsel_o(utmi_termsel_o), .utmi_xcvrsel_o(utmi_xcvrsel_o), .otg_ctrl_o(otg_ctrl_o),
    .tx_se0_o(tx_se0_o), .tx_data_o(tx_data_o), .tx_enable_n_o(tx_enable_n_o),
    .fsls_serial_o(fsls_serial_o), .feature_o(feature_o), .token_valid_o(token_valid_o),
    .flag_output_port_a_o(flag_output_port_a_o));

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_dly = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, d_b, ra [0:8];
    logic [31:0] reg_wdata_i = 32'h0, rm [0:8], v, ser_w, func_w;
    logic [31:0] exp_q [$];
    logic [7:0] data, otg_c; logic rxv, rxa, rxe, ps_a, ps_b, ps_c, tok, op2, term, xcvr;
    logic [1:0] ls, opm; logic [5:0] otg; logic [2:0] srx; logic [3:0] txo; logic [7:0] feat;
    logic [31:0] rdata; logic [10:0] fr;
    int failures = 0, compares = 0, tok_n = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    uim_phy_model phy (.ref_clk_i(ref_clk_i), .data_o(data), .rxvalid_o(rxv), .rxactive_o(rxa),
        .rxerror_o(rxe), .ls_o(ls), .otg_o(otg), .srx_o(srx));
    uim_ctrl dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata),
        .utmi_data_i(data), .utmi_rxvalid_i(rxv), .utmi_rxactive_i(rxa), .utmi_rxerror_i(rxe),
        .utmi_linestate_i(ls), .otg_stat_i(otg), .serial_rx_i(srx), .utmi_opmode_o(opm),
        .utmi_opmode2_o(op2), .utmi_termsel_o(term), .utmi_xcvrsel_o(xcvr), .otg_ctrl_o(otg_c),
        .tx_se0_o(txo[3]), .tx_data_o(txo[2]), .tx_enable_n_o(txo[1]), .fsls_serial_o(txo[0]),
        .feature_o(feat), .token_valid_o(tok), .flag_output_port_a_o(ps_a),
        .flag_output_port_b_o(ps_b), .flag_output_port_c_o(ps_c));
    task chk_rd(input string n, input [31:0] e, input [31:0] g);
        compares++;
        if (g !== e) begin failures++; $display("ERROR %s exp %h got %h", n, e, g); end
    endtask
    task chk_out(input string n, input [31:0] e, input [31:0] g);
        compares++;
        if (g !== e) begin failures++; $display("ERROR %s exp %h got %h", n, e, g); end
    endtask
    // Word accesses only; strobes drop one edge after they rise
    task wr(input [7:0] a, input [31:0] d);
        @(posedge ref_clk_i) begin reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d; end
        @(posedge ref_clk_i) reg_wr_i <= 1'b0;
    endtask
    task rd(input [7:0] a, input [31:0] e);
        exp_q.push_back(e);
        @(posedge ref_clk_i) begin reg_rd_i <= 1'b1; reg_addr_i <= a; end
        @(posedge ref_clk_i) reg_rd_i <= 1'b0;
    endtask
    // Read data is settled by the falling edge after the read is taken
    always @(posedge ref_clk_i) rd_dly <= reg_rd_i;
    always @(negedge ref_clk_i) begin
        if (rd_dly) begin
            if (exp_q.size() == 0) chk_rd("read queue", 32'h1, 32'h0);
            else chk_rd("read data", exp_q.pop_front(), rdata);
        end
    end
    always @(posedge ref_clk_i) if (tok === 1'b1) tok_n++;
    task final_report;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Watchdog against a stuck run
    initial begin #500us; failures++; final_report; end
    initial begin
        ra = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h28, 8'h14, 8'h2c, 8'h30};
        rm = '{32'hf7, 32'h7f, 32'h1f, 32'hdf, 32'h7f, 32'h7ff, 32'h0, 32'h0, 32'h0};
        void'($urandom(44));
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 9; i++) rd(ra[i], (ra[i] == 8'h0c) ? 32'h7 : 32'h0);
        rd(8'h18, 32'h2); rd(8'h1c, 32'h0); rd(8'h44, 32'h0);
        // Random readback through the writable masks, read-only places ignore writes
        for (int i = 0; i < 9; i++) begin
            v = $urandom();
            wr(ra[i], v);
            rd(ra[i], v & rm[i]);
            if (ra[i] == 8'h0c) func_w = v & rm[i];
        end
        chk_out("func outputs", func_w, {27'h0, op2, opm, term, xcvr});
        ser_w = $urandom() & 32'hf;
        wr(8'h18, ser_w);
        @(negedge ref_clk_i);
        chk_out("serial outputs", ser_w, {28'h0, txo});
        wr(8'h00, $urandom());
        rd(8'h04, 32'h0); rd(8'h20, 32'h0); rd(8'h28, 32'h0); rd(8'h0c, func_w);
        v = $urandom();
        phy.set_lines(2'h1, 1'b0, v[5:0], v[8:6]);
        repeat (4) @(posedge ref_clk_i);
        rd(8'h14, {26'h0, v[5:0]}); rd(8'h18, {25'h0, v[8:6], ser_w[3:0]});
        wr(8'h08, 32'h25); wr(8'h04, 32'h01); wr(8'h24, 32'h40);
        phy.send(8'he1, 8'h25, 8'h05);
        rd(8'h2c, 32'h1); rd(8'h30, 32'h1a); rd(8'h1c, 32'h40);
        chk_out("port a", 32'h1, {31'h0, ps_a});
        phy.send(8'he1, 8'h24, 8'h05);
        rd(8'h1c, 32'h0); rd(8'h30, 32'h1a);
        chk_out("port a", 32'h0, {31'h0, ps_a});
        chk_out("token count", 32'd1, tok_n);
        wr(8'h20, 32'h40);
        phy.send(8'he1, 8'h25, 8'h05);
        phy.send(8'he1, 8'h24, 8'h05);
        rd(8'h1c, 32'h40);
        wr(8'h1c, 32'h40);
        rd(8'h1c, 32'h0);
        wr(8'h04, 32'h41);
        fr = $urandom();
        phy.send(8'ha5, fr[7:0], {5'h0, fr[10:8]});
        rd(8'h28, {21'h0, fr}); rd(8'h2c, 32'h5);
        chk_out("token count", 32'd3, tok_n);
        // Bad PID check nibble, then a CRC5 failure with checking on; neither is taken
        phy.send(8'hf1, 8'h25, 8'h05);
        wr(8'h04, 32'h43);
        phy.send(8'he1, 8'h25, 8'h05);
        chk_out("token count", 32'd3, tok_n);
        d_b = $urandom();
        phy.send(8'hc3, d_b, ~d_b);
        rd(8'h1c, 32'h44); rd(8'h2c, 32'h3);
        wr(8'h00, 32'h0); wr(8'h04, 32'h04); wr(8'h24, 32'h013800);
        for (int i = 0; i < 3; i++) begin
            phy.set_lines((i == 0) ? 2'h0 : (i == 1) ? 2'h2 : 2'h1, 1'b0, v[5:0], v[8:6]);
            repeat (4) @(posedge ref_clk_i);
            rd(8'h1c, 32'h20 >> i);
            chk_out("port b", 32'h1, {31'h0, ps_b});
        end
        chk_out("port c", 32'h0, {31'h0, ps_c});
        phy.set_lines(2'h1, 1'b1, v[5:0], v[8:6]);
        repeat (4) @(posedge ref_clk_i);
        rd(8'h1c, 32'h09);
        chk_out("port c", 32'h1, {31'h0, ps_c});
        // Held receive-active flag survives the end of the packet
        wr(8'h20, 32'h02);
        phy.send(8'he1, 8'h25, 8'h05);
        rd(8'h1c, 32'h0b);
        for (int i = 0; i < 10 && exp_q.size() != 0; i++) @(posedge ref_clk_i);
        if (exp_q.size() != 0) failures++;
        final_report;
    end
endmodule
